/* File: hw/llpc_pkg.sv */
package llpc_pkg;
    // system clock
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_DIV_A = 8'h01;
    localparam logic [7:0] IDX_DIV_B = 8'h02;
    localparam logic [7:0] IDX_LOOP = 8'h03;
    localparam logic [7:0] IDX_PHASE = 8'h04;
    localparam logic [7:0] IDX_CFG = 8'h05;
    localparam logic [7:0] IDX_STAT = 8'h06;
    localparam logic [7:0] IDX_HS_POL = 8'h12;
    localparam logic [7:0] IDX_CO_POL = 8'h18;
    localparam logic [7:0] IDX_GEAR = 8'h36;
    // field positions
    localparam int DIVB_LSB = 4;
    localparam int BAND_LSB = 6;
    localparam int PUMP_LSB = 3;
    localparam int PHASE_LSB = 3;
    localparam int CFG_EXT_BIT = 0;
    localparam int CFG_ICOAST_BIT = 1;
    localparam int HSPOL_LSB = 4;
    localparam int COPOL_LSB = 5;
    localparam int GEAR_BIT = 0;
    // reset values
    localparam logic [11:0] DIV_RST = 12'h320;
    localparam logic [1:0] BAND_RST = 2'h0;
    localparam logic [2:0] PUMP_RST = 3'h5;
    localparam logic [1:0] POL_RST = 2'h1;
    // divisor limits
    localparam logic [11:0] DIV_MIN = 12'h002;
    localparam logic [11:0] DIV_MAX = 12'hfff;
    // oscillator model: frequency word units per MHz of pixel clock
    localparam int FW_W = 16;
    localparam int FW_PER_MHZ = 200;
    localparam logic [15:0] FW_RST = 16'h13ab;
    localparam int PHASE_STEPS = 32;

    typedef struct packed {
        logic [11:0] div;
        logic [1:0] band;
        logic [2:0] pump;
        logic [4:0] phase;
        logic gear;
        logic ext_sel;
        logic icoast;
        logic [1:0] hs_pol;
        logic [1:0] co_pol;
    } llpc_cfg_s;

    typedef struct packed {
        logic pix_tick;
        logic samp_tick;
        logic line_sync;
    } llpc_tick_s;
endpackage : llpc_pkg

/* File: hw/llpc_top.sv */
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - The pixel clock is divided by the divisor and compared with line sync, and the error trims the frequency.
// - The pixel clock spans 10 MHz to 140 MHz as line rate times divisor.
// - The band field picks 10-21, 21-42, 42-84 or 84-140 MHz.
// - The pump field picks 50, 100, 150, 250, 350, 500, 750 or 1500 uA of loop drive.
// - The phase field shifts sampling in 32 steps of 11.25 degrees within one pixel.
// - The line sync output carries the same phase shift as the sampling clock.
// - With an external pixel clock, phase adjust works only for offsets the ramp reaches within one external clock period.
// - While coast is on, from pin or internal, the loop runs on ignoring line sync.
// - Coast polarity sits in bits 6 to 5 of register 0x18.
// - Line sync polarity sits in bits 5 to 4 of register 0x12.
// - A polarity value of 1 means active high.
// - Internal coast is taken from vertical sync, covering the equalization pulses.
module llpc_top
    import llpc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // video sync pins
    input wire logic line_sync_in,
    input wire logic coast_in,
    input wire logic vsync_in,
    input wire logic ext_pix_clk_in,
    // clock datapath
    output logic pix_tick,
    output logic samp_tick,
    output logic phase_aligned_line_sync_out,
    output logic [FW_W-1:0] freq_word,
    output logic locked,
    output logic coast_active,
    // analog loop controls
    output logic osc_band_select_hi,
    output logic osc_band_select_lo,
    output logic pump_current_sel_2,
    output logic pump_current_sel_1,
    output logic pump_current_sel_0,
    output logic oscillator_gear_bit
);
    initial begin
        if (ADDR_W < 10) begin
            $error("llpc_top: ADDR_W must be at least 10");
        end
    end

    // band limits in frequency word units
    function automatic logic [FW_W-1:0] band_min(input logic [1:0] b);
        case (b)
            2'h0: band_min = FW_W'(10 * FW_PER_MHZ);
            2'h1: band_min = FW_W'(21 * FW_PER_MHZ);
            2'h2: band_min = FW_W'(42 * FW_PER_MHZ);
            default: band_min = FW_W'(84 * FW_PER_MHZ);
        endcase
    endfunction : band_min

    function automatic logic [FW_W-1:0] band_max(input logic [1:0] b);
        case (b)
            2'h0: band_max = FW_W'(21 * FW_PER_MHZ);
            2'h1: band_max = FW_W'(42 * FW_PER_MHZ);
            2'h2: band_max = FW_W'(84 * FW_PER_MHZ);
            default: band_max = FW_W'(140 * FW_PER_MHZ);
        endcase
    endfunction : band_max

    // correction per compare, proportional to pump current in 50 uA units
    function automatic logic [FW_W-1:0] pump_step(input logic [2:0] p, input logic g);
        logic [FW_W-1:0] s;
        case (p)
            3'h0: s = 16'h0001;
            3'h1: s = 16'h0002;
            3'h2: s = 16'h0003;
            3'h3: s = 16'h0005;
            3'h4: s = 16'h0007;
            3'h5: s = 16'h000a;
            3'h6: s = 16'h000f;
            default: s = 16'h001e;
        endcase
        // gear lowers the gain for slow line rates
        pump_step = g ? {1'b0, s[FW_W-1:1]} : s;
    endfunction : pump_step

    // value 1 means active high
    function automatic logic pol_act(input logic lvl, input logic [1:0] pol);
        pol_act = (pol == 2'h1) ? lvl : ~lvl;
    endfunction : pol_act

    // ---------------- register file ----------------
    llpc_cfg_s cfg_r, cfg_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic err_r, err_nxt;
    logic [7:0] idx;
    logic hit;
    logic wr_en;
    logic [7:0] wb;
    logic [7:0] rd;

    assign idx = paddr[9:2];
    assign wb = pwdata[7:0];
    assign wr_en = psel && penable && pwrite && hit;

    always_comb begin
        hit = 1'b1;
        rd = 8'h00;
        case (idx)
            IDX_DIV_A: rd = cfg_r.div[11:4];
            IDX_DIV_B: rd = {cfg_r.div[3:0], 4'h0};
            IDX_LOOP: rd = {cfg_r.band, cfg_r.pump, 3'h0};
            IDX_PHASE: rd = {cfg_r.phase, 3'h0};
            IDX_CFG: rd = {6'h00, cfg_r.icoast, cfg_r.ext_sel};
            IDX_STAT: rd = {6'h00, coast_active, locked};
            IDX_HS_POL: rd = {2'h0, cfg_r.hs_pol, 4'h0};
            IDX_CO_POL: rd = {1'b0, cfg_r.co_pol, 5'h00};
            IDX_GEAR: rd = {7'h00, cfg_r.gear};
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        cfg_nxt = cfg_r;
        prdata_nxt = prdata_r;
        err_nxt = err_r;
        // data and error are captured in setup so the access phase answers at once
        if (psel && !penable) begin
            prdata_nxt = pwrite ? 32'h0 : {24'h0, rd};
            err_nxt = ~hit;
        end
        if (wr_en) begin
            case (idx)
                IDX_DIV_A: cfg_nxt.div[11:4] = wb;
                IDX_DIV_B: cfg_nxt.div[3:0] = wb[DIVB_LSB+:4];
                IDX_LOOP: begin
                    cfg_nxt.band = wb[BAND_LSB+:2];
                    cfg_nxt.pump = wb[PUMP_LSB+:3];
                end
                IDX_PHASE: cfg_nxt.phase = wb[PHASE_LSB+:5];
                IDX_CFG: begin
                    cfg_nxt.ext_sel = wb[CFG_EXT_BIT];
                    cfg_nxt.icoast = wb[CFG_ICOAST_BIT];
                end
                IDX_HS_POL: cfg_nxt.hs_pol = wb[HSPOL_LSB+:2];
                IDX_CO_POL: cfg_nxt.co_pol = wb[COPOL_LSB+:2];
                IDX_GEAR: cfg_nxt.gear = wb[GEAR_BIT];
                default: cfg_nxt = cfg_r;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_r <= '{DIV_RST, BAND_RST, PUMP_RST, 5'h00, 1'b0, 1'b0, 1'b0, POL_RST, POL_RST};
            prdata_r <= 32'h0;
            err_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            prdata_r <= prdata_nxt;
            err_r <= err_nxt;
        end
    end

    assign pready = psel && penable;
    assign prdata = prdata_r;
    assign pslverr = psel && penable && err_r;
    assign osc_band_select_hi = cfg_r.band[1];
    assign osc_band_select_lo = cfg_r.band[0];
    assign pump_current_sel_2 = cfg_r.pump[2];
    assign pump_current_sel_1 = cfg_r.pump[1];
    assign pump_current_sel_0 = cfg_r.pump[0];
    assign oscillator_gear_bit = cfg_r.gear;

    // ---------------- pin synchronisers ----------------
    logic [3:0] sy1_r, sy2_r;
    logic ext_prev_r, hs_prev_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sy1_r <= 4'h0;
            sy2_r <= 4'h0;
            ext_prev_r <= 1'b0;
        end else begin
            sy1_r <= {ext_pix_clk_in, vsync_in, coast_in, line_sync_in};
            sy2_r <= sy1_r;
            ext_prev_r <= sy2_r[3];
        end
    end

    logic hs_act, ext_edge, hs_rise, coast_now;
    assign hs_act = pol_act(sy2_r[0], cfg_r.hs_pol);
    assign ext_edge = sy2_r[3] & ~ext_prev_r;
    assign hs_rise = hs_act & ~hs_prev_r;
    // pin or internal coast, internal coast follows vertical sync
    assign coast_now = pol_act(sy2_r[1], cfg_r.co_pol) | (cfg_r.icoast & sy2_r[2]);

    // ---------------- loop ----------------
    logic [FW_W-1:0] acc_r, acc_nxt, fw_r, fw_nxt;
    logic [11:0] cnt_r, cnt_nxt, div_eff;
    logic lock_r, lock_nxt, coast_r;
    logic smsb_r;
    llpc_tick_s tk_r, tk_nxt;
    logic [FW_W:0] sum, up;
    logic [FW_W-1:0] shifted, step, dn, lo, hi;
    logic tick;

    // divisor below the minimum is served as the minimum
    assign div_eff = (cfg_r.div < DIV_MIN) ? DIV_MIN : cfg_r.div;
    // frequency clamped to the band at each compare, overall 10 to 140 MHz
    assign lo = band_min(cfg_r.band);
    assign hi = band_max(cfg_r.band);
    assign step = pump_step(cfg_r.pump, cfg_r.gear);

    always_comb begin
        sum = {1'b0, acc_r} + {1'b0, fw_r};
        up = {1'b0, fw_r} + {1'b0, step};
        dn = (fw_r > step) ? fw_r - step : '0;
        // external clock restarts the phase ramp on each edge
        tick = cfg_r.ext_sel ? ext_edge : sum[FW_W];
        acc_nxt = (cfg_r.ext_sel && ext_edge) ? '0 : sum[FW_W-1:0];
        // sampling ramp offset by phase steps
        shifted = acc_nxt - {cfg_r.phase, 11'h000};
        cnt_nxt = cnt_r;
        if (tick) begin
            cnt_nxt = (cnt_r == div_eff - 12'h001) ? 12'h000 : cnt_r + 12'h001;
        end
        fw_nxt = fw_r;
        lock_nxt = lock_r;
        if (hs_rise && !coast_r) begin
            // early wrap means too fast, late means too slow
            lock_nxt = (cnt_r == 12'h000) || (cnt_r == div_eff - 12'h001);
            if (cnt_r != 12'h000) begin
                fw_nxt = (cnt_r < {1'b0, div_eff[11:1]}) ? dn : up[FW_W-1:0];
                if (up[FW_W] && cnt_r >= {1'b0, div_eff[11:1]}) begin
                    fw_nxt = hi;
                end
            end
            if (fw_nxt < lo) begin
                fw_nxt = lo;
            end
            if (fw_nxt > hi) begin
                fw_nxt = hi;
            end
        end
        tk_nxt.pix_tick = tick;
        tk_nxt.samp_tick = smsb_r & ~shifted[FW_W-1];
        // line sync retimed on the shifted sampling edge
        tk_nxt.line_sync = tk_nxt.samp_tick ? hs_act : tk_r.line_sync;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc_r <= '0;
            fw_r <= FW_RST;
            cnt_r <= 12'h000;
            lock_r <= 1'b0;
            coast_r <= 1'b0;
            smsb_r <= 1'b0;
            hs_prev_r <= 1'b0;
            tk_r <= '0;
        end else begin
            acc_r <= acc_nxt;
            fw_r <= fw_nxt;
            cnt_r <= cnt_nxt;
            lock_r <= lock_nxt;
            coast_r <= coast_now;
            smsb_r <= shifted[FW_W-1];
            hs_prev_r <= hs_act;
            tk_r <= tk_nxt;
        end
    end

    assign pix_tick = tk_r.pix_tick;
    assign samp_tick = tk_r.samp_tick;
    assign phase_aligned_line_sync_out = tk_r.line_sync;
    assign freq_word = fw_r;
    assign locked = lock_r;
    assign coast_active = coast_r;

    // ---------------- checks ----------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_wrap;
        tick && cnt_r == div_eff - 12'h001;
    endsequence

    chk_div_wrap: assert property (s_wrap |=> cnt_r == 12'h000)
        else $error("divider did not wrap at divisor");

    chk_band_clamp: assert property (hs_rise && !coast_r |=> fw_r >= $past(lo) && fw_r <= $past(hi))
        else $error("frequency word outside band");

    // every coasting cycle skips the compare, not just the first few
    chk_coast_hold: assert property (coast_r |=> $stable(fw_r))
        else $error("frequency moved during coast");

    // registered ticks reflect the settings of one and two edges back
    chk_phase_zero: assert property ($past(cfg_r.phase) == 5'h00 && $past(cfg_r.phase, 2) == 5'h00
        && !$past(cfg_r.ext_sel) |-> samp_tick == pix_tick)
        else $error("zero phase sample not on pixel tick");

    chk_sync_align: assert property ($changed(phase_aligned_line_sync_out) |-> samp_tick)
        else $error("line sync out moved off sampling edge");

    chk_ext_tick: assert property (cfg_r.ext_sel && ext_edge |=> pix_tick && acc_r == '0)
        else $error("external edge gave no pixel tick");

    chk_coast_pol: assert property (cfg_r.co_pol == 2'h1 && sy2_r[1] |=> coast_active)
        else $error("active high coast not seen");

    chk_int_coast: assert property (cfg_r.icoast && sy2_r[2] |=> coast_active)
        else $error("internal coast missed vertical sync");

    chk_apb_ready: assert property (psel && !penable ##1 psel && penable |-> pready)
        else $error("apb access not answered");
endmodule : llpc_top

/* File: tb/llpc_vid_src.sv */
`timescale 1ns/1ps
module llpc_vid_src #(
    // 50 kHz line rate times 800 stays in range
    parameter int LINE_NS = 20000,
    parameter int PULSE_NS = 2000,
    parameter int EXT_NS = 100
) (
    // controls
    input wire logic en,
    input wire logic act_high,
    input wire logic ext_en,
    // pins
    output logic line_sync,
    output logic ext_clk
);
    initial begin
        line_sync = 1'b0;
        ext_clk = 1'b0;
    end
    // idle level follows polarity, pulse only while enabled
    always begin
        line_sync = ~act_high;
        #(LINE_NS - PULSE_NS);
        if (en)
            line_sync = act_high;
        #(PULSE_NS);
    end
    // external clock stands still when not in use
    always begin
        #(EXT_NS / 2);
        if (ext_en)
            ext_clk = ~ext_clk;
    end
endmodule : llpc_vid_src

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench
    import llpc_pkg::*;
;
    typedef struct packed {logic wr; logic [7:0] idx; logic [7:0] wd; logic [7:0] rd; logic er;} llpc_row_s;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic pready, pslverr, e, df, lk, coast_in = 1'b0, vsync_in = 1'b0;
    logic src_en = 1'b0, src_hi = 1'b1, ext_en = 1'b0, line_sync_in, ext_pix_clk_in;
    logic pix_tick, samp_tick, phase_aligned_line_sync_out, locked, coast_active, pso_q = 1'b0, samp_q = 1'b0;
    logic osc_band_select_hi, osc_band_select_lo, pump_current_sel_2, pump_current_sel_1, pump_current_sel_0;
    logic oscillator_gear_bit;
    logic [15:0] freq_word, fw;
    int error_cnt = 0, n_checks = 0, cyc = 0, np, ns;
    llpc_row_s rows [21] = '{
        '{1'b0, IDX_DIV_A, 8'h00, 8'h32, 1'b0}, '{1'b0, IDX_DIV_B, 8'h00, 8'h00, 1'b0},
        '{1'b0, IDX_LOOP, 8'h00, 8'h28, 1'b0}, '{1'b0, IDX_PHASE, 8'h00, 8'h00, 1'b0},
        '{1'b0, IDX_CFG, 8'h00, 8'h00, 1'b0}, '{1'b0, IDX_STAT, 8'h00, 8'h00, 1'b0},
        '{1'b0, IDX_HS_POL, 8'h00, 8'h10, 1'b0}, '{1'b0, IDX_CO_POL, 8'h00, 8'h20, 1'b0},
        '{1'b0, IDX_GEAR, 8'h00, 8'h00, 1'b0}, '{1'b1, IDX_DIV_B, 8'hff, 8'h00, 1'b0},
        '{1'b0, IDX_DIV_B, 8'h00, 8'hf0, 1'b0}, '{1'b1, 8'h07, 8'hff, 8'h00, 1'b1},
        '{1'b0, 8'h07, 8'h00, 8'h00, 1'b1}, '{1'b1, IDX_STAT, 8'hff, 8'h00, 1'b0},
        '{1'b0, IDX_STAT, 8'h00, 8'h00, 1'b0}, '{1'b1, IDX_HS_POL, 8'hff, 8'h00, 1'b0},
        '{1'b0, IDX_HS_POL, 8'h00, 8'h30, 1'b0}, '{1'b1, IDX_CO_POL, 8'hff, 8'h00, 1'b0},
        '{1'b0, IDX_CO_POL, 8'h00, 8'h60, 1'b0}, '{1'b1, IDX_PHASE, 8'hff, 8'h00, 1'b0},
        '{1'b0, IDX_PHASE, 8'h00, 8'hf8, 1'b0}};

    always #12.5 clk = ~clk;

    llpc_top i_llpc_top (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .line_sync_in, .coast_in, .vsync_in, .ext_pix_clk_in, .pix_tick, .samp_tick, .phase_aligned_line_sync_out,
        .freq_word, .locked, .coast_active, .osc_band_select_hi, .osc_band_select_lo, .pump_current_sel_2,
        .pump_current_sel_1, .pump_current_sel_0, .oscillator_gear_bit);
    llpc_vid_src i_llpc_vid_src (.en(src_en), .act_high(src_hi), .ext_en(ext_en), .line_sync(line_sync_in),
        .ext_clk(ext_pix_clk_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    // one transfer; returns on the falling edge so outputs have settled
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask : apb

    task automatic count(input int n);
        np = 0;
        ns = 0;
        df = 1'b0;
        repeat (n) begin
            @(negedge clk);
            np += int'(pix_tick);
            ns += int'(samp_tick);
            if (pix_tick !== samp_tick)
                df = 1'b1;
        end
    endtask : count

    always @(posedge clk) begin
        cyc <= cyc + 1;
        pso_q <= phase_aligned_line_sync_out;
        samp_q <= samp_tick;
        if (!reset && phase_aligned_line_sync_out !== pso_q)
            chk(32'(samp_tick | samp_q), 32'h1);
        if (cyc == 40000) begin
            error_cnt++;
            end_sim();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].idx, rows[i].wd);
            chk(32'(e), 32'(rows[i].er));
            if (!rows[i].wr)
                chk(d, {24'h0, rows[i].rd});
        end
        apb(1'b1, IDX_HS_POL, 8'h10);
        apb(1'b1, IDX_CO_POL, 8'h20);
        apb(1'b1, IDX_PHASE, 8'h00);
        apb(1'b1, IDX_DIV_B, 8'h00);
        // every band and pump code reaches the pins
        for (int i = 0; i < 32; i++) begin
            apb(1'b1, IDX_LOOP, 8'(i << 3));
            chk({osc_band_select_hi, osc_band_select_lo, pump_current_sel_2, pump_current_sel_1,
                pump_current_sel_0}, 32'(i));
        end
        apb(1'b1, IDX_GEAR, 8'h01);
        chk(32'(oscillator_gear_bit), 32'h1);
        apb(1'b1, IDX_GEAR, 8'h00);
        chk(32'(oscillator_gear_bit), 32'h0);
        // reset word lies below band 10, compares pull it in
        apb(1'b1, IDX_LOOP, 8'hb8);
        src_en <= 1'b1;
        repeat (4000) @(posedge clk);
        chk(32'(freq_word >= 16'h20d0 && freq_word <= 16'h41a0), 32'h1);
        @(posedge clk);
        coast_in <= 1'b1;
        count(10);
        chk(32'(coast_active), 32'h1);
        fw = freq_word;
        lk = locked;
        count(2400);
        chk(32'(freq_word), 32'(fw));
        chk(32'(locked), 32'(lk));
        apb(1'b0, IDX_STAT, 8'h00);
        chk(32'(d[1]), 32'h1);
        apb(1'b1, IDX_CO_POL, 8'h00);
        count(6);
        chk(32'(coast_active), 32'h0);
        @(posedge clk);
        coast_in <= 1'b0;
        count(6);
        chk(32'(coast_active), 32'h1);
        apb(1'b1, IDX_CO_POL, 8'h20);
        count(6);
        chk(32'(coast_active), 32'h0);
        apb(1'b1, IDX_CFG, 8'h02);
        @(posedge clk);
        vsync_in <= 1'b1;
        count(6);
        chk(32'(coast_active), 32'h1);
        @(posedge clk);
        vsync_in <= 1'b0;
        count(6);
        chk(32'(coast_active), 32'h0);
        apb(1'b1, IDX_CFG, 8'h00);
        // line sync polarity seen at the output
        src_en <= 1'b0;
        count(900);
        chk(32'(phase_aligned_line_sync_out), 32'h0);
        src_hi <= 1'b0;
        count(900);
        chk(32'(phase_aligned_line_sync_out), 32'h1);
        apb(1'b1, IDX_HS_POL, 8'h00);
        count(40);
        chk(32'(phase_aligned_line_sync_out), 32'h0);
        apb(1'b1, IDX_HS_POL, 8'h10);
        // phase zero aligns, half turn separates
        count(200);
        chk(32'(df), 32'h0);
        apb(1'b1, IDX_PHASE, 8'h80);
        count(400);
        chk(32'(ns > 0 && df), 32'h1);
        // external clock keeps phase adjust
        // ramp restarts on each external edge, so the offset must be reached within one period
        apb(1'b1, IDX_PHASE, 8'h20);
        apb(1'b1, IDX_CFG, 8'h01);
        ext_en <= 1'b1;
        count(20);
        count(400);
        chk(32'(np >= 98 && np <= 101 && ns > 0 && df), 32'h1);
        end_sim();
    end
endmodule : testbench
